// ===== core/amdr_pkg.sv
// Notes on behaviour
// - alarm word marks its type with bits 23 and 22 both at one
// - device-wide over-temperature: latched copy bit 21, live copy bit 20
// - latched bit sets on an event and stays; live bit follows condition now
// - writing one to clear bit 6 resets every latched alarm whose condition is no longer present
// - guard pairs channels 0..3 in bits 19..12, latched bit higher
// - clamp pairs channels 0..3 in bits 11..4, latched bit higher
// - any guard or clamp alarm drives the shared open-drain fault pin
// - open-drain over-temperature pin follows the over-temperature condition
// - dac readback is one 24-bit word: type, address, contents
// - top bits: 01 gain, 10 offset, 11 input code
// - bits 21..16 echo the six-bit dac address that was read
// - bits 15..0 carry the 16-bit contents of the addressed register
// - after power-on the alarm word reads all flags set, low four zero
package amdr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 24;
  localparam int CHANS = 4;
  localparam int SEL_W = 6;
  localparam int DAC_W = 16;
  localparam int DAC_DEPTH = 64;
  localparam int IRQ_W = 4;
  // register byte addresses
  localparam logic [7:0] OFF_ALARM = 8'h00;
  localparam logic [7:0] OFF_DAC_RB = 8'h04;
  localparam logic [7:0] OFF_DAC_REQ = 8'h08;
  localparam logic [7:0] OFF_DAC_WR = 8'h0C;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1C;
  // field positions
  localparam int TYPE_HI = 23;
  localparam int TYPE_LO = 22;
  localparam int SEL_LO = 16;
  localparam int CLEAR_BIT = 6;
  localparam int IRQ_OT = 0;
  localparam int IRQ_GUARD = 1;
  localparam int IRQ_CLAMP = 2;
  localparam int IRQ_DAC = 3;
  // word type codes
  localparam logic [1:0] TYPE_ALARM = 2'h3;
  localparam logic [1:0] TYPE_GAIN = 2'h1;
  localparam logic [1:0] TYPE_OFFSET = 2'h2;
  localparam logic [1:0] TYPE_INPUT = 2'h3;
  localparam logic [1:0] TYPE_NONE = 2'h0;
  // reset values
  localparam logic [15:0] GAIN_RST = 16'hFFFF;
  localparam logic [15:0] OFFSET_RST = 16'h8000;
  localparam logic [3:0] LOW_ZERO = 4'h0;
  localparam logic [23:0] ALARM_RST = 24'hFFFFF0;

  typedef struct packed {
    logic overtemp;
    logic [CHANS-1:0] guard;
    logic [CHANS-1:0] clamp;
  } amdr_alarm_in_t;

  typedef struct packed {
    logic [1:0] word_type;
    logic [SEL_W-1:0] dac_select;
    logic [DAC_W-1:0] dac_contents;
  } amdr_dac_word_t;
endpackage

// ===== core/amdr_flag_latch.sv
`timescale 1ns/1ps
`default_nettype none
// sticky and live copies of a group of alarm conditions
module amdr_flag_latch #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] cond,
  input wire logic clr,
  output logic [W-1:0] sticky_q,
  output logic [W-1:0] live_q,
  output logic rise_q
);
  logic [W-1:0] sticky_d;
  logic [W-1:0] live_d;
  logic rise_d;

  // set wins over clear so an event in the clear cycle survives
  always_comb begin
    sticky_d = (sticky_q & ~{W{clr}}) | cond;
    live_d = cond;
    rise_d = |(cond & ~live_q);
  end

  // power-on shows every flag set
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sticky_q <= '1;
      live_q <= '1;
      rise_q <= 1'b0;
    end else begin
      sticky_q <= sticky_d;
      live_q <= live_d;
      rise_q <= rise_d;
    end
  end

  sticky_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!clr && $past(!clr)) |-> ((sticky_q & $past(sticky_q)) == $past(sticky_q)))
    else $error("sticky flag dropped without clear");
  clear_works_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clr && cond == '0) |=> (sticky_q == '0))
    else $error("clear did not empty sticky flags");
endmodule
`default_nettype wire

// ===== core/amdr_top.sv
`timescale 1ns/1ps
`default_nettype none
// alarm status and dac readback words behind an apb slave
module amdr_top #(
  parameter int CHANS = amdr_pkg::CHANS,
  parameter logic [15:0] INPUT_RST = 16'h0000
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [amdr_pkg::ADDR_W-1:0] paddr,
  input wire logic [amdr_pkg::DATA_W-1:0] pwdata,
  output logic [amdr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire amdr_pkg::amdr_alarm_in_t alarm_in,
  output logic overtemp_pin_o,
  output logic overtemp_pin_oe,
  output logic shared_fault_pin_o,
  output logic shared_fault_pin_oe,
  output logic irq
);
  localparam int DW = amdr_pkg::DAC_W;
  localparam int SW = amdr_pkg::SEL_W;
  localparam int DEPTH = amdr_pkg::DAC_DEPTH;
  localparam int IW = amdr_pkg::IRQ_W;

  // interleave latched/live pairs, channel 0 at the top
  function automatic logic [2*amdr_pkg::CHANS-1:0] pairs(
    input logic [amdr_pkg::CHANS-1:0] s,
    input logic [amdr_pkg::CHANS-1:0] l
  );
    logic [2*amdr_pkg::CHANS-1:0] r;
    r = '0;
    for (int i = 0; i < amdr_pkg::CHANS; i++) begin
      r[2*(amdr_pkg::CHANS-1-i)+1] = s[i];
      r[2*(amdr_pkg::CHANS-1-i)] = l[i];
    end
    return r;
  endfunction

  // only gain, offset and input codes name a dac register
  function automatic logic type_ok(input logic [1:0] t);
    return t != amdr_pkg::TYPE_NONE;
  endfunction

  // ---------------- alarm latches ----------------
  logic clr_alarm;
  logic ot_s, ot_l, ot_rise;
  logic [CHANS-1:0] g_s, g_l, c_s, c_l;
  logic g_rise, c_rise;

  amdr_flag_latch #(.W(1)) u_ot (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cond(alarm_in.overtemp),
    .clr(clr_alarm),
    .sticky_q(ot_s),
    .live_q(ot_l),
    .rise_q(ot_rise)
  );
  amdr_flag_latch #(.W(CHANS)) u_guard (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cond(alarm_in.guard),
    .clr(clr_alarm),
    .sticky_q(g_s),
    .live_q(g_l),
    .rise_q(g_rise)
  );
  amdr_flag_latch #(.W(CHANS)) u_clamp (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .cond(alarm_in.clamp),
    .clr(clr_alarm),
    .sticky_q(c_s),
    .live_q(c_l),
    .rise_q(c_rise)
  );

  // alarm status word assembly
  logic [amdr_pkg::WORD_W-1:0] alarm_word;
  always_comb begin
    alarm_word = {amdr_pkg::TYPE_ALARM, ot_s, ot_l,
                  pairs(g_s, g_l),
                  pairs(c_s, c_l),
                  amdr_pkg::LOW_ZERO};
  end

  // ---------------- apb decode ----------------
  logic access, commit, wr_commit;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [amdr_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic mapped, bad_type;
  amdr_pkg::amdr_dac_word_t wr_word;

  assign access = psel && penable;
  assign commit = access && pready_q;
  assign wr_commit = commit && pwrite && !pslverr_q;
  assign wr_word = pwdata[amdr_pkg::WORD_W-1:0];

  // ---------------- dac registers and readback ----------------
  logic [DW-1:0] gain_q [DEPTH];
  logic [DW-1:0] gain_d [DEPTH];
  logic [DW-1:0] offs_q [DEPTH];
  logic [DW-1:0] offs_d [DEPTH];
  logic [DW-1:0] inp_q [DEPTH];
  logic [DW-1:0] inp_d [DEPTH];
  amdr_pkg::amdr_dac_word_t rb_q, rb_d;
  logic rb_done_q, rb_done_d;

  // writes land in the array named by the word type
  always_comb begin
    gain_d = gain_q;
    offs_d = offs_q;
    inp_d = inp_q;
    if (wr_commit && paddr == amdr_pkg::OFF_DAC_WR) begin
      case (wr_word.word_type)
        amdr_pkg::TYPE_GAIN: gain_d[wr_word.dac_select] = wr_word.dac_contents;
        amdr_pkg::TYPE_OFFSET: offs_d[wr_word.dac_select] = wr_word.dac_contents;
        amdr_pkg::TYPE_INPUT: inp_d[wr_word.dac_select] = wr_word.dac_contents;
        default: inp_d = inp_q;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        gain_q[i] <= amdr_pkg::GAIN_RST;
        offs_q[i] <= amdr_pkg::OFFSET_RST;
        inp_q[i] <= INPUT_RST;
      end
    end else begin
      gain_q <= gain_d;
      offs_q <= offs_d;
      inp_q <= inp_d;
    end
  end

  // readback request captures type and address, fetches contents
  always_comb begin
    rb_d = rb_q;
    rb_done_d = 1'b0;
    if (wr_commit && paddr == amdr_pkg::OFF_DAC_REQ) begin
      rb_d.word_type = wr_word.word_type;
      rb_d.dac_select = wr_word.dac_select;
      case (wr_word.word_type)
        amdr_pkg::TYPE_GAIN: rb_d.dac_contents = gain_q[wr_word.dac_select];
        amdr_pkg::TYPE_OFFSET: rb_d.dac_contents = offs_q[wr_word.dac_select];
        amdr_pkg::TYPE_INPUT: rb_d.dac_contents = inp_q[wr_word.dac_select];
        default: rb_d.dac_contents = '0;
      endcase
      rb_done_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rb_q <= '0;
      rb_done_q <= 1'b0;
    end else begin
      rb_q <= rb_d;
      rb_done_q <= rb_done_d;
    end
  end

  // ---------------- interrupt registers ----------------
  logic [IW-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d, irq_evt, irq_clr;
  logic irq_q, irq_d;

  always_comb begin
    irq_evt = '0;
    irq_evt[amdr_pkg::IRQ_OT] = ot_rise;
    irq_evt[amdr_pkg::IRQ_GUARD] = g_rise;
    irq_evt[amdr_pkg::IRQ_CLAMP] = c_rise;
    irq_evt[amdr_pkg::IRQ_DAC] = rb_done_q;
    irq_clr = '0;
    if (wr_commit && paddr == amdr_pkg::OFF_IRQ_CLR) begin
      irq_clr = pwdata[IW-1:0];
    end
    irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt; // set wins over clear
    irq_en_d = irq_en_q;
    if (wr_commit && paddr == amdr_pkg::OFF_IRQ_EN) begin
      irq_en_d = pwdata[IW-1:0];
    end
    irq_d = |(irq_stat_q & irq_en_q);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end

  // clear bit of the channel configuration register
  assign clr_alarm = wr_commit && paddr == amdr_pkg::OFF_CFG
                     && pwdata[amdr_pkg::CLEAR_BIT];

  // ---------------- apb answer, one wait state ----------------
  always_comb begin
    mapped = 1'b0;
    case (paddr)
      amdr_pkg::OFF_ALARM, amdr_pkg::OFF_DAC_RB, amdr_pkg::OFF_IRQ_STAT,
      amdr_pkg::OFF_IRQ_EN: mapped = 1'b1;
      amdr_pkg::OFF_DAC_REQ, amdr_pkg::OFF_DAC_WR, amdr_pkg::OFF_CFG,
      amdr_pkg::OFF_IRQ_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    bad_type = pwrite && (paddr == amdr_pkg::OFF_DAC_REQ || paddr == amdr_pkg::OFF_DAC_WR)
               && !type_ok(wr_word.word_type);
    pready_d = access && !pready_q;
    pslverr_d = access && !pready_q && (!mapped || bad_type);
    prdata_d = '0;
    if (access && !pready_q && !pwrite) begin
      case (paddr)
        amdr_pkg::OFF_ALARM: prdata_d = {8'h00, alarm_word};
        amdr_pkg::OFF_DAC_RB: prdata_d = {8'h00, rb_q};
        amdr_pkg::OFF_IRQ_STAT: prdata_d = {{(amdr_pkg::DATA_W-IW){1'b0}}, irq_stat_q};
        amdr_pkg::OFF_IRQ_EN: prdata_d = {{(amdr_pkg::DATA_W-IW){1'b0}}, irq_en_q};
        default: prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ---------------- open-drain alarm pins ----------------
  logic ot_oe_q, ot_oe_d, fault_oe_q, fault_oe_d;
  always_comb begin
    ot_oe_d = alarm_in.overtemp;
    fault_oe_d = |alarm_in.guard || |alarm_in.clamp;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ot_oe_q <= 1'b1;
      fault_oe_q <= 1'b1;
    end else begin
      ot_oe_q <= ot_oe_d;
      fault_oe_q <= fault_oe_d;
    end
  end

  assign overtemp_pin_o = 1'b0;
  assign shared_fault_pin_o = 1'b0;
  assign overtemp_pin_oe = ot_oe_q;
  assign shared_fault_pin_oe = fault_oe_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // ---------------- checks ----------------
  alarm_type_bits_a: assert property (@(posedge mclk) disable iff (sys_rst)
    alarm_word[amdr_pkg::TYPE_HI:amdr_pkg::TYPE_LO] == amdr_pkg::TYPE_ALARM)
    else $error("alarm word type bits wrong");
  overtemp_bits_a: assert property (@(posedge mclk) disable iff (sys_rst)
    alarm_in.overtemp |=> (alarm_word[21] && alarm_word[20]))
    else $error("over-temperature bits not set");
  guard_ch0_pair_a: assert property (@(posedge mclk) disable iff (sys_rst)
    alarm_in.guard[0] |=> (alarm_word[19:18] == 2'h3))
    else $error("guard channel 0 pair misplaced");
  clamp_ch3_pair_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!sys_rst && !alarm_in.clamp[3]) |=> !alarm_word[4])
    else $error("clamp channel 3 live bit misplaced");
  fault_pin_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (|alarm_in.guard || |alarm_in.clamp) |=> shared_fault_pin_oe)
    else $error("shared fault pin not driven");
  overtemp_pin_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !sys_rst |=> overtemp_pin_oe == $past(alarm_in.overtemp))
    else $error("over-temperature pin does not follow");
  low_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    alarm_word[3:0] == 4'h0)
    else $error("alarm word low bits nonzero");
  dac_echo_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_commit && paddr == amdr_pkg::OFF_DAC_REQ)
    |=> (rb_q.dac_select == $past(wr_word.dac_select) && rb_q.word_type ==
         $past(wr_word.word_type) && rb_done_q))
    else $error("dac readback type or address not echoed");
  gain_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_commit && paddr == amdr_pkg::OFF_DAC_REQ
     && wr_word.word_type == amdr_pkg::TYPE_GAIN)
    |=> rb_q.dac_contents == $past(gain_q[wr_word.dac_select]))
    else $error("gain contents not returned");
  apb_ready_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (access && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("apb answer not after one wait state");
endmodule
`default_nettype wire

// ===== test/amdr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// apb master standing in for the host controller
module amdr_host_model (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  int n_tmo = 0;
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer, held until pready is seen high or 50 clocks pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_tmo++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== test/alarm_and_dac_readback_tb.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_and_dac_readback_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e;
  logic ot_o, ot_oe, sf_o, sf_oe;
  amdr_pkg::amdr_alarm_in_t ain = '1;
  int n_errors = 0;
  int total_checks = 0;
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  amdr_host_model amdr_host_model_i (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  amdr_top amdr_top_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_in(ain), .overtemp_pin_o(ot_o), .overtemp_pin_oe(ot_oe),
    .shared_fault_pin_o(sf_o), .shared_fault_pin_oe(sf_oe), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    amdr_host_model_i.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    amdr_host_model_i.xfer(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  // expected alarm word from sticky and live copies
  function automatic logic [31:0] aw(logic os, logic ol, logic [3:0] gs, logic [3:0] gl,
                                     logic [3:0] cs, logic [3:0] cl);
    logic [31:0] v;
    v = 32'h00C00000;
    v[21] = os;
    v[20] = ol;
    for (int i = 0; i < 4; i++) begin
      v[19-2*i] = gs[i];
      v[18-2*i] = gl[i];
      v[11-2*i] = cs[i];
      v[10-2*i] = cl[i];
    end
    return v;
  endfunction
  task automatic pins(input logic ot, input logic sf);
    repeat (3) @(posedge mclk);
    chk({30'h0, ot_oe, sf_oe}, {30'h0, ot, sf});
    chk({30'h0, ot_o, sf_o}, 32'h0);
  endtask
  task automatic t_reset;
    // conditions held high from reset keep live copies set as well
    rd(amdr_pkg::OFF_ALARM, 32'h00FFFFF0, 1'b0);
    pins(1'b1, 1'b1);
    rd(8'hFC, 32'h0, 1'b1);
    ain <= '0;
    $display("test reset done");
  endtask
  task automatic t_alarm;
    wr(amdr_pkg::OFF_CFG, 32'h40, 1'b0);
    rd(amdr_pkg::OFF_ALARM, 32'h00C00000, 1'b0);
    @(posedge mclk);
    ain <= '{overtemp: 1'b1, guard: 4'h3, clamp: 4'h4};
    pins(1'b1, 1'b1);
    rd(amdr_pkg::OFF_ALARM, aw(1, 1, 4'h3, 4'h3, 4'h4, 4'h4), 1'b0);
    ain <= '0;
    pins(1'b0, 1'b0);
    rd(amdr_pkg::OFF_ALARM, aw(1, 0, 4'h3, 0, 4'h4, 0), 1'b0);
    ain <= '{overtemp: 1'b0, guard: 4'h0, clamp: 4'h8};
    pins(1'b0, 1'b1);
    wr(amdr_pkg::OFF_CFG, 32'h40, 1'b0);
    rd(amdr_pkg::OFF_ALARM, aw(0, 0, 0, 0, 4'h8, 4'h8), 1'b0);
    ain <= '0;
    wr(amdr_pkg::OFF_CFG, 32'h40, 1'b0);
    rd(amdr_pkg::OFF_ALARM, 32'h00C00000, 1'b0);
    $display("test alarm done");
  endtask
  task automatic t_dac;
    logic [1:0] t;
    rd(amdr_pkg::OFF_DAC_REQ, 32'h0, 1'b0);
    wr(amdr_pkg::OFF_DAC_REQ, {8'h0, 2'h1, 6'h09, 16'h0}, 1'b0);
    rd(amdr_pkg::OFF_DAC_RB, {8'h0, 2'h1, 6'h09, 16'hFFFF}, 1'b0);
    wr(amdr_pkg::OFF_DAC_REQ, {8'h0, 2'h2, 6'h09, 16'h0}, 1'b0);
    rd(amdr_pkg::OFF_DAC_RB, {8'h0, 2'h2, 6'h09, 16'h8000}, 1'b0);
    wr(amdr_pkg::OFF_DAC_WR, {8'h0, 2'h0, 6'h01, 16'h1234}, 1'b1);
    for (int i = 1; i < 4; i++) begin
      t = 2'(i);
      wr(amdr_pkg::OFF_DAC_WR, {8'h0, t, 6'h20 + 6'(i), 16'hA5C0 + 16'(i)}, 1'b0);
      wr(amdr_pkg::OFF_DAC_REQ, {8'h0, t, 6'h20 + 6'(i), 16'h0}, 1'b0);
      rd(amdr_pkg::OFF_DAC_RB, {8'h0, t, 6'h20 + 6'(i), 16'hA5C0 + 16'(i)},
         1'b0);
    end
    $display("test dac done");
  endtask
  task automatic t_irq;
    wr(amdr_pkg::OFF_IRQ_CLR, 32'hF, 1'b0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(amdr_pkg::OFF_IRQ_EN, 32'h8, 1'b0);
    rd(amdr_pkg::OFF_IRQ_EN, 32'h8, 1'b0);
    wr(amdr_pkg::OFF_DAC_REQ, {8'h0, 2'h3, 6'h02, 16'h0}, 1'b0);
    repeat (4) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rd(amdr_pkg::OFF_IRQ_STAT, 32'h8, 1'b0);
    wr(amdr_pkg::OFF_IRQ_CLR, 32'h8, 1'b0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask
  task automatic summarize;
    n_errors += amdr_host_model_i.n_tmo;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_alarm();
    t_dac();
    t_irq();
    summarize();
  end
endmodule
`default_nettype wire
